//--- common/bus_ctl_params.svh
// constants of the bus controller command interpreter: codes, bit positions, reset values, timing
`ifndef BUS_CTL_PARAMS_SVH
`define BUS_CTL_PARAMS_SVH

// ************************************************************
// timing
// ************************************************************
`define CLK_MHZ 10
`define HOLD_US 100
`define HOLD_CYC (`HOLD_US * `CLK_MHZ)
`define SYNC_DELAY_NS 1500
`define SYNC_DELAY_CYC ((`SYNC_DELAY_NS * `CLK_MHZ + 999) / 1000)
`define UNIT_LONG_CYC 1800
`define UNIT_SHORT_CYC 45

// ************************************************************
// operation and utility command codes
// ************************************************************
`define CMD_COUNT_OFF 8'hF0
`define CMD_RESET 8'hF2
`define CMD_CLR_IRQ 8'hF3
`define CMD_STBY_CNT 8'hF4
`define CMD_PPOLL 8'hF5
`define CMD_STBY 8'hF6
`define CMD_LOCAL 8'hF7
`define CMD_REMOTE 8'hF8
`define CMD_ABORT 8'hF9
`define CMD_TAKE 8'hFA
`define CMD_TAKE_ASYNC 8'hFC
`define CMD_TAKE_SYNC 8'hFD
`define CMD_COUNT_ON 8'hFE
`define CMD_WR_TMO 8'hE1
`define CMD_WR_EVC 8'hE2
`define CMD_RD_EVC 8'hE3
`define CMD_RD_ERR 8'hE4
`define CMD_RD_IMASK 8'hE5
`define CMD_RD_CST 8'hE6
`define CMD_RD_BUS 8'hE7
`define CMD_RD_TMO 8'hE9
`define CMD_RD_EMASK 8'hEA
`define IRQ_ACKNOWLEDGE_CMD_MASK 8'h0B

// ************************************************************
// field positions and reset values
// ************************************************************
`define ERR_HANDOVER 0
`define ERR_STBY 1
`define ERR_SYNC 2
`define ERR_USER 5
`define ERR_MASK_BITS 8'h27
`define ST_ERR 6
`define ACK_BITS 8'hF4
`define IM_OBF 0
`define IM_IBF 1
`define IM_TCI 2
`define IM_SPI 3
`define DATA_IMASK_SEL 7
`define BYTE_RST 8'h00
`define MASK4_RST 4'h0

`endif

//--- common/bus_ctl_pkg.sv
// types of the bus controller command interpreter
package bus_ctl_pkg;
	// controller function state
	typedef enum logic [1:0] {CTL_IDLE = 2'b00, CTL_ACTIVE = 2'b01, CTL_STANDBY = 2'b10} ctl_state_t;
	// background wait loops watched by the timeout timer
	typedef enum logic [1:0] {WAIT_NONE = 2'b00, WAIT_TAKE = 2'b01, WAIT_SYNC = 2'b10, WAIT_STBY = 2'b11} wait_t;
	// fixed-length holds on bus lines
	typedef enum logic [2:0] {HOLD_NONE = 3'b000, HOLD_REN = 3'b001, HOLD_IFC = 3'b010, HOLD_BOOT = 3'b011,
		HOLD_SYNC = 3'b100} hold_t;
	// meaning of the next data byte
	typedef enum logic [1:0] {DATA_MASK = 2'b00, DATA_TMO = 2'b01, DATA_EVC = 2'b10} data_t;
endpackage : bus_ctl_pkg

//--- hw/ctl_timer.sv
// timeout timer: prescaled 8-bit down counter with expiry pulse
`timescale 1ns/1ps
`include "bus_ctl_params.svh"
module ctl_timer (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic start,
	input wire logic run,
	input wire logic unitLong,
	input wire logic [7:0] loadVal,
	output logic [7:0] countVal,
	output logic expire
);
	logic [10:0] preCnt_r; // cycles within one count unit
	logic [7:0] cnt_r; // remaining units, kept after stop for status reads
	logic fired_r; // expiry already reported for this wait
	logic expire_r; // one-cycle expiry pulse
	logic tick; // last cycle of a unit
	logic [10:0] unitLast; // last prescale value

	assign unitLast = unitLong ? 11'(`UNIT_LONG_CYC - 1) : 11'(`UNIT_SHORT_CYC - 1);
	assign tick = run && !fired_r && preCnt_r == unitLast;
	assign countVal = cnt_r;
	assign expire = expire_r;

	// ************************************************************
	// counter
	// ************************************************************
	// start reloads; running counts down one unit at a time and flags once at zero
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			preCnt_r <= 11'h000;
			cnt_r <= `BYTE_RST;
			fired_r <= 1'b0;
			expire_r <= 1'b0;
		end else if (start) begin
			preCnt_r <= 11'h000;
			cnt_r <= loadVal;
			fired_r <= 1'b0;
			expire_r <= 1'b0;
		end else begin
			expire_r <= tick && cnt_r == 8'h00;
			if (tick) begin
				preCnt_r <= 11'h000;
				if (cnt_r == 8'h00) begin
					fired_r <= 1'b1;
				end else begin
					cnt_r <= cnt_r - 8'h01;
				end
			end else if (run && !fired_r) begin
				preCnt_r <= preCnt_r + 11'h001;
			end
		end
	end
endmodule : ctl_timer

//--- hw/bus_controller.sv
// command interpreter of the bus controller: host buffer, commands, bus control lines, interrupts
`timescale 1ns/1ps
`include "bus_ctl_params.svh"
module bus_controller import bus_ctl_pkg::*; (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic registerSelectLine,
	input wire logic [7:0] wrData,
	input wire logic wrStrobe,
	input wire logic rdStrobe,
	output logic [7:0] rdData,
	input wire logic attentionSenseIn,
	input wire logic davTrue,
	input wire logic eoiIn,
	input wire logic srqIn,
	input wire logic ifcIn,
	input wire logic sysCtrlIn,
	input wire logic countIn,
	output logic attentionDriveOut,
	output logic controllerInChargeOut,
	output logic eoiDriveOut,
	output logic renAssertOut,
	output logic ifcAssertOut,
	output logic outBufferFullIrq,
	output logic inBufferFreeIrq,
	output logic taskDoneIrq,
	output logic specialIrq
);
	// ************************************************************
	// storage
	// ************************************************************
	logic cmdValid_r, cmdSel_r; // input buffer full and its select
	logic [7:0] cmdByte_r; // input buffer byte
	ctl_state_t ctlState_r, state_nxt; // controller function state
	wait_t waitKind_r, wait_nxt; // background wait loop
	hold_t holdKind_r, hold_nxt; // running line hold
	logic [9:0] holdCnt_r; // hold elapsed cycles
	logic atn_r, atn_nxt, cic_r, cic_nxt; // low asserts
	logic eoi_r, eoi_nxt, ren_r, ren_nxt, ifc_r, ifc_nxt; // high asserts
	logic takeAfter_r, takeAfter_nxt; // take control after IFC
	logic bootPend_r; // reset just released
	logic cntEn_r, cntEn_nxt, cntIrq_r, cntIrq_nxt; // counter enable, count interrupt enable
	data_t dataPend_r; // meaning of next data byte
	logic [7:0] tmoReg_r, evcReg_r, evcStat_r, errFlags_r, errMask_r, status_r, outBuf_r;
	logic [3:0] irqMask_r; // interrupt mask
	logic obf_r, taskDone_r, specialPend_r; // pending buffer and interrupt flags
	logic sysPrev_r, srqPrev_r, ifcPrev_r, countPrev_r; // edge history
	logic [7:0] rdData_r;
	logic obfIrq_r, ibfIrq_r, tciIrq_r, spiIrq_r;

	// ************************************************************
	// decode
	// ************************************************************
	logic isCmd, isAck, cmdHit, doReset, clrAll, dataWr, holdFree, holdDone, holdStart;
	logic countEdge, evEvent, tmrStart, tmrExpire, tciSet, bufLoad;
	logic [7:0] bufVal, errSet, flagSet, ackClr, tmrVal;

	// last cycle of each hold kind
	function automatic logic [9:0] holdLimit(input hold_t k);
		holdLimit = (k == HOLD_SYNC) ? 10'(`SYNC_DELAY_CYC - 1) : 10'(`HOLD_CYC - 1);
	endfunction : holdLimit

	assign isCmd = cmdValid_r && cmdSel_r;
	assign isAck = isCmd && ((cmdByte_r & `IRQ_ACKNOWLEDGE_CMD_MASK) == `IRQ_ACKNOWLEDGE_CMD_MASK);
	assign cmdHit = isCmd && !isAck;
	assign doReset = cmdHit && cmdByte_r == `CMD_RESET;
	assign clrAll = cmdHit && cmdByte_r == `CMD_CLR_IRQ;
	assign dataWr = cmdValid_r && !cmdSel_r;
	assign holdFree = holdKind_r == HOLD_NONE;
	assign holdDone = !holdFree && holdCnt_r == holdLimit(holdKind_r);
	assign countEdge = countIn && !countPrev_r;
	assign evEvent = cntEn_r && cntIrq_r && ctlState_r == CTL_STANDBY && countEdge && evcStat_r == 8'h01;
	assign ackClr = isAck ? (cmdByte_r & `ACK_BITS) : `BYTE_RST;
	assign flagSet = {sysCtrlIn ^ sysPrev_r && !bootPend_r, |(errSet & errMask_r), srqIn && !srqPrev_r, evEvent,
		1'b0, ifcIn && !ifcPrev_r, 2'b00};

	// timeout timer for the wait loops
	ctl_timer u_timer (
		.clk(clk),
		.rst_b(rst_b),
		.start(tmrStart),
		.run(waitKind_r != WAIT_NONE),
		.unitLong(waitKind_r != WAIT_STBY),
		.loadVal(tmoReg_r),
		.countVal(tmrVal),
		.expire(tmrExpire)
	);

	// ************************************************************
	// command execution
	// ************************************************************
	// next controller state from holds, wait loops, boot and the current command
	always_comb begin
		state_nxt = ctlState_r;
		wait_nxt = waitKind_r;
		hold_nxt = holdKind_r;
		atn_nxt = atn_r;
		cic_nxt = cic_r;
		eoi_nxt = eoi_r;
		ren_nxt = ren_r;
		ifc_nxt = ifc_r;
		takeAfter_nxt = takeAfter_r;
		cntEn_nxt = cntEn_r;
		cntIrq_nxt = cntIrq_r;
		holdStart = 1'b0;
		tmrStart = 1'b0;
		tciSet = 1'b0;
		bufLoad = 1'b0;
		bufVal = `BYTE_RST;
		errSet = `BYTE_RST;
		// end of a hold
		if (holdDone) begin
			hold_nxt = HOLD_NONE;
			case (holdKind_r)
				HOLD_REN: tciSet = 1'b1;
				HOLD_IFC: begin
					ifc_nxt = 1'b0;
					if (takeAfter_r) begin
						wait_nxt = WAIT_TAKE;
						tmrStart = 1'b1;
					end else begin
						tciSet = 1'b1;
					end
				end
				HOLD_BOOT: begin
					ifc_nxt = 1'b0;
					cic_nxt = 1'b0;
				end
				HOLD_SYNC: begin
					atn_nxt = 1'b0;
					state_nxt = CTL_ACTIVE;
					wait_nxt = WAIT_NONE;
					tciSet = 1'b1;
				end
				default: ;
			endcase
		end
		// wait loops
		case (waitKind_r)
			WAIT_TAKE: begin
				if (attentionSenseIn) begin
					atn_nxt = 1'b0;
					cic_nxt = 1'b0;
					state_nxt = CTL_ACTIVE;
					wait_nxt = WAIT_NONE;
					tciSet = 1'b1;
				end else if (tmrExpire) begin
					errSet[`ERR_HANDOVER] = 1'b1;
				end
			end
			WAIT_SYNC: begin
				if (!davTrue && holdFree) begin
					hold_nxt = HOLD_SYNC;
					holdStart = 1'b1;
				end else if (tmrExpire && holdKind_r != HOLD_SYNC) begin
					errSet[`ERR_SYNC] = 1'b1;
				end
			end
			WAIT_STBY: begin
				if (davTrue) begin
					wait_nxt = WAIT_NONE;
				end else if (tmrExpire) begin
					errSet[`ERR_STBY] = 1'b1;
					wait_nxt = WAIT_NONE;
				end
			end
			default: ;
		endcase
		// abort sequence after reset when system controller
		if (bootPend_r && sysCtrlIn) begin
			ifc_nxt = 1'b1;
			hold_nxt = HOLD_BOOT;
			holdStart = 1'b1;
		end
		// operation and utility commands
		if (cmdHit) begin
			eoi_nxt = 1'b0;
			case (cmdByte_r)
				`CMD_COUNT_OFF: begin
					cntIrq_nxt = 1'b0;
					tciSet = 1'b1;
				end
				`CMD_CLR_IRQ: wait_nxt = WAIT_NONE;
				`CMD_STBY_CNT: begin
					atn_nxt = 1'b1;
					cntEn_nxt = 1'b1;
					if (ctlState_r == CTL_ACTIVE) begin
						cntIrq_nxt = 1'b1;
						state_nxt = CTL_STANDBY;
						wait_nxt = WAIT_STBY;
						tmrStart = 1'b1;
						tciSet = 1'b1;
					end
				end
				`CMD_PPOLL: begin
					if (ctlState_r == CTL_ACTIVE) begin
						atn_nxt = 1'b0;
						eoi_nxt = 1'b1;
					end
				end
				`CMD_STBY: begin
					if (ctlState_r == CTL_ACTIVE) begin
						atn_nxt = 1'b1;
						state_nxt = CTL_STANDBY;
						wait_nxt = WAIT_STBY;
						tmrStart = 1'b1;
						tciSet = 1'b1;
					end
				end
				`CMD_LOCAL: begin
					if (!sysCtrlIn) begin
						errSet[`ERR_USER] = 1'b1;
					end else if (holdFree) begin
						ren_nxt = 1'b0;
						hold_nxt = HOLD_REN;
						holdStart = 1'b1;
					end
				end
				`CMD_REMOTE: begin
					if (!sysCtrlIn) begin
						errSet[`ERR_USER] = 1'b1;
					end else begin
						ren_nxt = ren_r || holdKind_r != HOLD_REN;
						tciSet = 1'b1;
					end
				end
				`CMD_ABORT: begin
					if (!sysCtrlIn) begin
						errSet[`ERR_USER] = 1'b1;
					end else if (holdFree) begin
						ifc_nxt = 1'b1;
						hold_nxt = HOLD_IFC;
						holdStart = 1'b1;
						takeAfter_nxt = ctlState_r == CTL_IDLE;
					end
				end
				`CMD_TAKE: begin
					if (ctlState_r == CTL_IDLE) begin
						wait_nxt = WAIT_TAKE;
						tmrStart = 1'b1;
					end
				end
				`CMD_TAKE_ASYNC: begin
					if (ctlState_r == CTL_STANDBY) begin
						atn_nxt = 1'b0;
						state_nxt = CTL_ACTIVE;
						wait_nxt = WAIT_NONE;
						tciSet = 1'b1;
					end
				end
				`CMD_TAKE_SYNC: begin
					if (ctlState_r == CTL_STANDBY) begin
						wait_nxt = WAIT_SYNC;
						tmrStart = 1'b1;
					end
				end
				`CMD_COUNT_ON: begin
					cntIrq_nxt = 1'b1;
					tciSet = 1'b1;
				end
				`CMD_RD_EVC: bufVal = evcStat_r;
				`CMD_RD_ERR: bufVal = errFlags_r;
				`CMD_RD_IMASK: bufVal = {4'h0, irqMask_r};
				`CMD_RD_CST: bufVal = {sysCtrlIn, ifc_r, ren_r, !cic_r, 2'b00, ctlState_r};
				`CMD_RD_BUS: bufVal = {ren_r, davTrue, eoiIn, 1'b0, sysCtrlIn, ifcIn, attentionSenseIn, srqIn};
				`CMD_RD_TMO: bufVal = tmrVal;
				`CMD_RD_EMASK: bufVal = errMask_r;
				default: ;
			endcase
			if (cmdByte_r[7:4] == 4'hE && cmdByte_r[3:0] >= 4'h3) begin
				bufLoad = 1'b1;
				tciSet = 1'b1;
			end
		end
		// acknowledge that leaves the error flag returns the error flags
		if (isAck && !cmdByte_r[`ST_ERR]) begin
			bufVal = errFlags_r;
			bufLoad = 1'b1;
			tciSet = 1'b1;
		end
	end

	// controller state registers
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ctlState_r <= CTL_IDLE;
			waitKind_r <= WAIT_NONE;
			holdKind_r <= HOLD_NONE;
			{atn_r, cic_r, eoi_r, ren_r, ifc_r} <= 5'b11000;
			{takeAfter_r, bootPend_r, cntEn_r, cntIrq_r} <= 4'b0100;
		end else if (doReset) begin
			ctlState_r <= CTL_IDLE;
			waitKind_r <= WAIT_NONE;
			holdKind_r <= HOLD_NONE;
			{atn_r, cic_r, eoi_r, ren_r, ifc_r} <= 5'b11000;
			{takeAfter_r, bootPend_r, cntEn_r, cntIrq_r} <= 4'b0100;
		end else begin
			ctlState_r <= state_nxt;
			waitKind_r <= wait_nxt;
			holdKind_r <= hold_nxt;
			{atn_r, cic_r, eoi_r, ren_r, ifc_r} <= {atn_nxt, cic_nxt, eoi_nxt, ren_nxt, ifc_nxt};
			{takeAfter_r, bootPend_r, cntEn_r, cntIrq_r} <= {takeAfter_nxt, 1'b0, cntEn_nxt, cntIrq_nxt};
		end
	end

	// hold length counter
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			holdCnt_r <= 10'h000;
		end else if (holdStart || doReset) begin
			holdCnt_r <= 10'h000;
		end else if (!holdFree) begin
			holdCnt_r <= holdCnt_r + 10'h001;
		end
	end

	// ************************************************************
	// host buffers and registers
	// ************************************************************
	// input buffer takes each written byte; it is consumed the next cycle
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			{cmdValid_r, cmdSel_r, cmdByte_r} <= {2'b00, `BYTE_RST};
		end else begin
			{cmdValid_r, cmdSel_r, cmdByte_r} <= {wrStrobe, registerSelectLine, wrData};
		end
	end

	// data bytes: pending timeout or counter value, else direct mask write
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			dataPend_r <= DATA_MASK;
			{tmoReg_r, errMask_r, irqMask_r} <= {`BYTE_RST, `BYTE_RST, `MASK4_RST};
		end else if (doReset) begin
			dataPend_r <= DATA_MASK;
			{tmoReg_r, errMask_r, irqMask_r} <= {`BYTE_RST, `BYTE_RST, `MASK4_RST};
		end else if (cmdHit && cmdByte_r == `CMD_WR_TMO) begin
			dataPend_r <= DATA_TMO;
		end else if (cmdHit && cmdByte_r == `CMD_WR_EVC) begin
			dataPend_r <= DATA_EVC;
		end else if (dataWr) begin
			dataPend_r <= DATA_MASK;
			if (dataPend_r == DATA_TMO) begin
				tmoReg_r <= cmdByte_r;
			end else if (dataPend_r == DATA_MASK && cmdByte_r[`DATA_IMASK_SEL]) begin
				irqMask_r <= cmdByte_r[3:0];
			end else if (dataPend_r == DATA_MASK) begin
				errMask_r <= cmdByte_r & `ERR_MASK_BITS;
			end
		end
	end

	// event counter: load, then count down on rising count input while enabled
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			{evcReg_r, evcStat_r, countPrev_r} <= {`BYTE_RST, `BYTE_RST, 1'b0};
		end else if (doReset) begin
			{evcReg_r, evcStat_r, countPrev_r} <= {`BYTE_RST, `BYTE_RST, countIn};
		end else begin
			countPrev_r <= countIn;
			if (dataWr && dataPend_r == DATA_EVC) begin
				evcReg_r <= cmdByte_r;
				evcStat_r <= cmdByte_r;
			end else if (cmdHit && cmdByte_r == `CMD_STBY_CNT && ctlState_r == CTL_ACTIVE) begin
				evcStat_r <= evcReg_r;
			end else if (cntEn_r && countEdge) begin
				evcStat_r <= evcStat_r - 8'h01;
			end
		end
	end

	// ************************************************************
	// flags and interrupts
	// ************************************************************
	// sticky flags; a set in the clearing cycle wins
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			{errFlags_r, status_r} <= {`BYTE_RST, `BYTE_RST};
			{specialPend_r, taskDone_r, sysPrev_r, srqPrev_r, ifcPrev_r} <= 5'b00000;
		end else if (doReset) begin
			{errFlags_r, status_r} <= {`BYTE_RST, `BYTE_RST};
			{specialPend_r, taskDone_r, sysPrev_r, srqPrev_r, ifcPrev_r} <= {2'b00, sysCtrlIn, srqIn, ifcIn};
		end else begin
			{sysPrev_r, srqPrev_r, ifcPrev_r} <= {sysCtrlIn, srqIn, ifcIn};
			errFlags_r <= (clrAll ? `BYTE_RST : errFlags_r) | errSet;
			status_r <= (clrAll ? `BYTE_RST : status_r & ~ackClr) | flagSet;
			taskDone_r <= (isCmd ? 1'b0 : taskDone_r) | tciSet;
			if (isAck) begin
				specialPend_r <= |(status_r & ~ackClr) || |flagSet;
			end else begin
				specialPend_r <= (specialPend_r && !clrAll) || |flagSet;
			end
		end
	end

	// output buffer: loaded by read commands, emptied by host data read
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			{outBuf_r, obf_r} <= {`BYTE_RST, 1'b0};
		end else if (bufLoad) begin
			{outBuf_r, obf_r} <= {bufVal, 1'b1};
		end else if (doReset || (rdStrobe && !registerSelectLine)) begin
			obf_r <= 1'b0;
		end
	end

	// read port and masked interrupt outputs
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rdData_r <= `BYTE_RST;
			{obfIrq_r, ibfIrq_r, tciIrq_r, spiIrq_r} <= 4'h0;
		end else begin
			rdData_r <= !rdStrobe ? `BYTE_RST : registerSelectLine ?
				{status_r[7:4], taskDone_r, status_r[2], cmdValid_r, obf_r} : outBuf_r;
			obfIrq_r <= obf_r && irqMask_r[`IM_OBF];
			ibfIrq_r <= !cmdValid_r && irqMask_r[`IM_IBF];
			tciIrq_r <= taskDone_r && irqMask_r[`IM_TCI];
			spiIrq_r <= specialPend_r && irqMask_r[`IM_SPI];
		end
	end

	assign rdData = rdData_r;
	assign attentionDriveOut = atn_r;
	assign controllerInChargeOut = cic_r;
	assign eoiDriveOut = eoi_r;
	assign renAssertOut = ren_r;
	assign ifcAssertOut = ifc_r;
	assign outBufferFullIrq = obfIrq_r;
	assign inBufferFreeIrq = ibfIrq_r;
	assign taskDoneIrq = tciIrq_r;
	assign specialIrq = spiIrq_r;

	// ************************************************************
	// checks
	// ************************************************************
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);

	soft_reset_a: assert property (doReset |=> ctlState_r == CTL_IDLE && atn_r && cic_r && errFlags_r == 8'h00
		&& irqMask_r == 4'h0 && waitKind_r == WAIT_NONE) else $error("reset command left state behind");
	clr_irq_a: assert property (clrAll && !tciSet && flagSet == 8'h00 |=> !taskDone_r && !specialPend_r
		&& waitKind_r == WAIT_NONE) else $error("interrupt reset left a pending item");
	ppoll_a: assert property (cmdHit && cmdByte_r == `CMD_PPOLL && ctlState_r == CTL_ACTIVE && !holdDone
		|=> !atn_r && eoi_r && !taskDone_r) else $error("parallel poll lines or interrupt wrong");
	ren_low_a: assert property (cmdHit && cmdByte_r == `CMD_LOCAL && sysCtrlIn && holdFree
		|=> (!ren_r && holdKind_r == HOLD_REN)[*8]) else $error("REN not held false");
	user_err_a: assert property (cmdHit && cmdByte_r == `CMD_REMOTE && !sysCtrlIn
		|=> errFlags_r[`ERR_USER] && $stable(ren_r)) else $error("remote without system control");
	ifc_hold_a: assert property (holdKind_r == HOLD_IFC && !holdDone && !doReset
		|=> ifc_r && holdKind_r == HOLD_IFC) else $error("IFC dropped early");
	take_ctl_a: assert property (waitKind_r == WAIT_TAKE && attentionSenseIn && !cmdHit
		|=> !atn_r && !cic_r && ctlState_r == CTL_ACTIVE && taskDone_r) else $error("take control failed");
	take_async_a: assert property (cmdHit && cmdByte_r == `CMD_TAKE_ASYNC && ctlState_r == CTL_STANDBY
		|=> !atn_r && ctlState_r == CTL_ACTIVE && taskDone_r) else $error("async take failed");
	read_reply_a: assert property (cmdHit && cmdByte_r == `CMD_RD_ERR
		|=> obf_r && outBuf_r == $past(errFlags_r) && taskDone_r ##1 outBufferFullIrq == irqMask_r[`IM_OBF])
		else $error("read reply wrong");
	tci_clear_a: assert property (isCmd && !tciSet |=> !taskDone_r) else $error("task done not cleared");
endmodule : bus_controller

//--- verification/bus_peer.sv
// bus side peer: another controller and the bus lines seen by the controller
`timescale 1ns/1ps
module bus_peer (
	input wire logic attentionDriveOut,
	input wire logic otherHolds,
	input wire logic countDrive,
	output logic attentionSenseIn,
	output logic davTrue,
	output logic eoiIn,
	output logic srqIn,
	output logic ifcIn,
	output logic countIn
);
	// the line reads released only when no party drives it low; otherHolds is the other controller
	assign attentionSenseIn = ~otherHolds & attentionDriveOut;
	assign davTrue = 1'b0; // no handshake running on the bus
	assign eoiIn = 1'b0;
	assign srqIn = 1'b0;
	assign ifcIn = 1'b0;
	assign countIn = countDrive; // count pin pulses come from the bench
endmodule : bus_peer

//--- verification/testbench.sv
// self-checking bench of the bus controller command interpreter
`timescale 1ns/1ps
module testbench import bus_ctl_pkg::*;;
	logic clk = 1'b0, rst_b = 1'b0, sel = 1'b0, wrStrobe = 1'b0, rdStrobe = 1'b0, sys = 1'b0;
	logic [7:0] wrData = 8'h00, rdData;
	logic atnIn, dav, eoi, srq, ifc, cnt, atn, controller_in_charge_out, eoiOut, ren, ifcOut, out_buffer_full_irq, in_buffer_free_irq, task_done_irq, spi;
	logic holdAtn = 1'b1, cntD = 1'b0; // other controller holds attention, count pin level
	int mismatches = 0, checksDone = 0;
	always #50 clk = ~clk;
	bus_controller u_dut (.clk(clk), .rst_b(rst_b), .registerSelectLine(sel), .wrData(wrData),
		.wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData), .attentionSenseIn(atnIn), .davTrue(dav),
		.eoiIn(eoi), .srqIn(srq), .ifcIn(ifc), .sysCtrlIn(sys), .countIn(cnt), .attentionDriveOut(atn),
		.controllerInChargeOut(controller_in_charge_out), .eoiDriveOut(eoiOut), .renAssertOut(ren), .ifcAssertOut(ifcOut),
		.outBufferFullIrq(out_buffer_full_irq), .inBufferFreeIrq(in_buffer_free_irq), .taskDoneIrq(task_done_irq), .specialIrq(spi));
	bus_peer u_peer (.attentionDriveOut(atn), .otherHolds(holdAtn), .countDrive(cntD),
		.attentionSenseIn(atnIn), .davTrue(dav), .eoiIn(eoi),
		.srqIn(srq), .ifcIn(ifc), .countIn(cnt));
	// compare and count
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checksDone++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	// one host write, then let the command land
	task automatic wr(input logic s, input logic [7:0] d);
		@(posedge clk);
		sel <= s;
		wrData <= d;
		wrStrobe <= 1'b1;
		@(posedge clk);
		wrStrobe <= 1'b0;
		repeat (3) @(posedge clk);
		#1;
	endtask : wr
	// read command, then read the output buffer
	task automatic rd(input logic [7:0] code, input logic [7:0] exp);
		wr(1'b1, code);
		chk(8'(task_done_irq), 8'h01);
		@(posedge clk);
		sel <= 1'b0;
		rdStrobe <= 1'b1;
		@(posedge clk);
		rdStrobe <= 1'b0;
		#1;
		chk(rdData, exp);
	endtask : rd
	// count pin pulses, one rising edge every second cycle
	task automatic pulse(input int n);
		repeat (n) begin
			@(posedge clk);
			cntD <= 1'b1;
			@(posedge clk);
			cntD <= 1'b0;
		end
		repeat (2) @(posedge clk);
		#1;
	endtask : pulse
	// masks written directly, read back
	task automatic t_masks;
		wr(1'b0, 8'h8F);
		chk(8'(in_buffer_free_irq), 8'h01);
		rd(8'hE5, 8'h0F);
		@(posedge clk);
		#1;
		chk(8'(out_buffer_full_irq), 8'h00);
		wr(1'b0, 8'h27);
		rd(8'hEA, 8'h27);
		$display("done masks");
	endtask : t_masks
	// user error, acknowledge, interrupt reset
	task automatic t_user;
		wr(1'b1, 8'hF8);
		chk(8'(ren), 8'h00);
		wr(1'b1, 8'hF7);
		rd(8'hE4, 8'h20);
		chk(8'(spi), 8'h01);
		wr(1'b1, 8'h4B);
		chk(8'(spi), 8'h00);
		wr(1'b1, 8'hF3);
		chk(8'(task_done_irq), 8'h00);
		rd(8'hE4, 8'h00);
		$display("done user");
	endtask : t_user
	// counter and timeout registers through data bytes
	task automatic t_regs;
		wr(1'b1, 8'hE2);
		wr(1'b0, 8'h07);
		chk(8'(task_done_irq), 8'h00);
		rd(8'hE3, 8'h07);
		wr(1'b1, 8'hE1);
		chk(8'(task_done_irq), 8'h00);
		wr(1'b0, 8'h05);
		chk(8'(task_done_irq), 8'h00);
		$display("done regs");
	endtask : t_regs
	// take control, standby, take back, poll
	task automatic t_take;
		wr(1'b1, 8'hFA);
		chk(8'(controller_in_charge_out), 8'h01);
		@(posedge clk);
		holdAtn <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
		chk({6'h00, atn, controller_in_charge_out}, 8'h00);
		chk(8'(task_done_irq), 8'h01);
		wr(1'b1, 8'hF6);
		chk({6'h00, atn, task_done_irq}, 8'h03);
		wr(1'b1, 8'hFC);
		chk({6'h00, atn, task_done_irq}, 8'h01);
		wr(1'b1, 8'hF5);
		chk({6'h00, eoiOut, task_done_irq}, 8'h02);
		$display("done take");
	endtask : t_take
	// standby with counting, standby timeout, acknowledge, synchronous take
	task automatic t_stby;
		wr(1'b1, 8'hFE);
		chk(8'(task_done_irq), 8'h01);
		wr(1'b1, 8'hF4);
		chk({6'h00, atn, task_done_irq}, 8'h03);
		pulse(6);
		chk(8'(spi), 8'h00);
		pulse(1);
		chk(8'(spi), 8'h01);
		repeat (300) @(posedge clk);
		rd(8'h1B, 8'h02);
		chk(8'(spi), 8'h01);
		rd(8'hE7, 8'h02);
		wr(1'b1, 8'h4B);
		chk(8'(spi), 8'h00);
		wr(1'b1, 8'hF0);
		pulse(258);
		chk(8'(spi), 8'h00);
		rd(8'hE3, 8'hFE);
		wr(1'b1, 8'hFD);
		chk(8'(atn), 8'h01);
		repeat (13) @(posedge clk);
		#1;
		chk(8'(atn), 8'h01);
		repeat (2) @(posedge clk);
		#1;
		chk({6'h00, atn, task_done_irq}, 8'h01);
		rd(8'hE6, 8'h11);
		$display("done standby");
	endtask : t_stby
	// system controller: remote, local hold, full reset
	task automatic t_sys;
		@(posedge clk);
		sys <= 1'b1;
		wr(1'b1, 8'hF8);
		chk(8'(ren), 8'h01);
		wr(1'b1, 8'hF7);
		repeat (990) @(posedge clk);
		#1;
		chk({6'h00, ren, task_done_irq}, 8'h00);
		repeat (20) @(posedge clk);
		#1;
		chk(8'(task_done_irq), 8'h01);
		wr(1'b1, 8'hF2);
		chk({5'h00, ren, ifcOut, controller_in_charge_out}, 8'h03);
		repeat (1010) @(posedge clk);
		#1;
		chk({6'h00, ifcOut, controller_in_charge_out}, 8'h00);
		wr(1'b0, 8'h8F);
		wr(1'b1, 8'hF9);
		chk(8'(ifcOut), 8'h01);
		repeat (1005) @(posedge clk);
		#1;
		chk({5'h00, ifcOut, atn, task_done_irq}, 8'h01);
		$display("done sys");
	endtask : t_sys
	// verdict and end of run
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", checksDone, mismatches);
		if (mismatches == 0 && checksDone > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : wrap_up
	// main sequence
	initial begin
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		#1;
		chk({4'h0, out_buffer_full_irq, in_buffer_free_irq, task_done_irq, spi}, 8'h00);
		chk({6'h00, atn, controller_in_charge_out}, 8'h03);
		t_masks();
		t_user();
		t_regs();
		t_take();
		t_stby();
		t_sys();
		wrap_up();
	end
	// watchdog against a hang
	initial begin
		#1000000;
		mismatches++;
		wrap_up();
	end
endmodule : testbench
